// ---- verilog/dcso_pkg.sv ----
// Purpose: Constants and types for the dual-channel sample output port
// Assumes: System clock of 250 MHz, sample clock sampled as a plain input
// Notes:   Register offsets are byte addresses on the plain register port
package dcso_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths and timing
  localparam int          SAMPLE_W     = 10;
  localparam int          CORE_W       = 12;
  localparam int          CNT_W        = 10;
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          LOST_TIME_NS = 1000;
  localparam int          LOST_CYC     = (LOST_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int          SYNC_W       = 6;

  // Synchroniser bit positions
  localparam int          SY_SCLK      = 0;
  localparam int          SY_SLPA      = 1;
  localparam int          SY_SLPB      = 2;
  localparam int          SY_OSTD      = 3;
  localparam int          SY_FSS0      = 4;
  localparam int          SY_FSS1      = 5;

  // Four-level select codes: bit 1 stabilizer, bit 0 two's complement
  localparam logic [1:0]  FSS_STAB_BIT = 2'h2;
  localparam logic [1:0]  FSS_TWOS_BIT = 2'h1;

  // Range limits of the ten-bit signed word
  localparam logic signed [CORE_W-1:0] MAX_CODE = 12'sh1FF;
  localparam logic signed [CORE_W-1:0] MIN_CODE = -12'sh200;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  REG_STATUS   = 4'h0;
  localparam logic [3:0]  REG_IRQ_STAT = 4'h4;
  localparam logic [3:0]  REG_IRQ_MASK = 4'h8;
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_LOST     = 0;
  localparam int          IRQ_OVR_A    = 1;
  localparam int          IRQ_OVR_B    = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Output bus word
  typedef struct packed {
    logic                 overrange;
    logic [SAMPLE_W-1:0]  sample_bits;
  } dcso_word_s;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_RUN   = 2'b01,
    ST_LOST  = 2'b10
  } dcso_state_e;

endpackage

// ---- verilog/dcso_port.sv ----
// Purpose: Digital output side of a dual-channel ten-bit sampling converter
// Assumes: Core codes arrive signed on clk; pins are asynchronous to clk
// Notes:   Channel A leads the strobe high, channel B leads it low
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcso_port
  import dcso_pkg::*;
#(
  parameter int LOST_CYCLES = LOST_CYC
) (
  // Clock and reset
  input  wire  logic                     clk,
  input  wire  logic                     rst,
  // Pins from the board
  input  wire  logic                     sample_clock,
  input  wire  logic                     sleep_input_a,
  input  wire  logic                     sleep_input_b,
  input  wire  logic                     output_standard_select,
  input  wire  logic [1:0]               format_stabilizer_select,
  // Converter core codes
  input  wire  logic signed [CORE_W-1:0] core_code_a,
  input  wire  logic signed [CORE_W-1:0] core_code_b,
  // Output bus
  output logic [SAMPLE_W-1:0]            sample_bits,
  output logic                           overrange,
  output logic                           output_strobe,
  output logic                           output_standard,
  // Register port
  input  wire  logic [ADDR_W-1:0]        reg_addr,
  input  wire  logic [31:0]              reg_wdata,
  input  wire  logic                     reg_wr,
  input  wire  logic                     reg_rd,
  output logic [31:0]                    reg_rdata,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////
  // Code to bus word with clipping and format choice
  function automatic dcso_word_s encode(input logic signed [CORE_W-1:0] c,
                                        input logic twos);
    dcso_word_s w;
    logic signed [CORE_W-1:0] v;
    v = c;
    w.overrange = 1'b0;
    if (c > MAX_CODE) begin
      v = MAX_CODE;
      w.overrange = 1'b1;
    end else if (c < MIN_CODE) begin
      v = MIN_CODE;
      w.overrange = 1'b1;
    end
    w.sample_bits = v[SAMPLE_W-1:0];
    if (!twos) begin
      w.sample_bits[SAMPLE_W-1] = ~v[SAMPLE_W-1];
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  logic [SYNC_W-1:0] sy1_r;
  logic [SYNC_W-1:0] sy2_r;
  logic              sclk_d_r;
  logic [SYNC_W-1:0] pins;

  assign pins = {format_stabilizer_select, output_standard_select,
                 sleep_input_b, sleep_input_a, sample_clock};

  // Two-stage capture and edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sy1_r    <= '0;
      sy2_r    <= '0;
      sclk_d_r <= 1'b0;
    end else begin
      sy1_r    <= pins;
      sy2_r    <= sy1_r;
      sclk_d_r <= sy2_r[SY_SCLK];
    end
  end

  logic rise_ev;
  logic fall_ev;
  logic stab_on;
  logic twos_on;
  logic sleep_a;
  logic sleep_b;

  assign rise_ev = sy2_r[SY_SCLK] & ~sclk_d_r;
  assign fall_ev = ~sy2_r[SY_SCLK] & sclk_d_r;
  assign stab_on = |({sy2_r[SY_FSS1], sy2_r[SY_FSS0]} & FSS_STAB_BIT);
  assign twos_on = |({sy2_r[SY_FSS1], sy2_r[SY_FSS0]} & FSS_TWOS_BIT);
  assign sleep_a = sy2_r[SY_SLPA];
  assign sleep_b = sy2_r[SY_SLPB];

  ////////////////////////////////////////////////////////////////////////
  // Stabilizer: period measure and mid-period fall event
  logic [CNT_W-1:0] since_rise_r;
  logic [CNT_W-1:0] since_rise_nxt;
  logic [CNT_W-1:0] half_r;
  logic [CNT_W-1:0] half_nxt;
  logic [15:0]      idle_r;
  logic [15:0]      idle_nxt;
  logic             b_ev;
  logic             lost_ev;

  // Count cycles between rises, keep half of the last period
  always_comb begin
    since_rise_nxt = since_rise_r;
    half_nxt       = half_r;
    idle_nxt       = idle_r;
    if (rise_ev) begin
      half_nxt       = (since_rise_r + 1'b1) >> 1;
      since_rise_nxt = '0;
      idle_nxt       = '0;
    end else begin
      if (~&since_rise_r) begin
        since_rise_nxt = since_rise_r + 1'b1;
      end
      if (idle_r != 16'hFFFF) begin
        idle_nxt = idle_r + 16'h0001;
      end
    end
  end

  assign b_ev    = stab_on ? (!rise_ev && since_rise_r + 1'b1 == half_r
                              && half_r != '0)
                           : fall_ev;
  assign lost_ev = (idle_r == LOST_CYCLES[15:0]) && !rise_ev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_rise_r <= '0;
      half_r       <= '0;
      idle_r       <= '0;
    end else begin
      since_rise_r <= since_rise_nxt;
      half_r       <= half_nxt;
      idle_r       <= idle_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output bus: word first, strobe edge one cycle after
  dcso_word_s  word_r;
  dcso_word_s  word_nxt;
  dcso_word_s  enc_a;
  dcso_word_s  enc_b;
  logic        phase_r;
  logic        phase_nxt;
  logic        strobe_r;
  logic        strobe_nxt;
  logic        ostd_r;
  dcso_state_e state_r;
  dcso_state_e state_nxt;

  assign enc_a = encode(core_code_a, twos_on);
  assign enc_b = encode(core_code_b, twos_on);

  // Channel A on rise, channel B on fall or stabilizer mid-period event, sleeping channel reads zero
  always_comb begin
    word_nxt   = word_r;
    phase_nxt  = phase_r;
    state_nxt  = state_r;
    strobe_nxt = phase_r && (state_r == ST_RUN);
    case (state_r)
      ST_SLEEP: begin
        word_nxt   = '0;
        phase_nxt  = 1'b0;
        strobe_nxt = 1'b0;
        if (!(sleep_a && sleep_b)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_a && sleep_b) begin
          state_nxt = ST_SLEEP;
        end else if (lost_ev) begin
          state_nxt = ST_LOST;
        end else if (rise_ev) begin
          word_nxt  = sleep_a ? '0 : enc_a;
          phase_nxt = 1'b1;
        end else if (b_ev) begin
          word_nxt  = sleep_b ? '0 : enc_b;
          phase_nxt = 1'b0;
        end
      end
      ST_LOST: begin
        phase_nxt  = 1'b0;
        strobe_nxt = 1'b0;
        if (sleep_a && sleep_b) begin
          state_nxt = ST_SLEEP;
        end else if (rise_ev) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r   <= '0;
      phase_r  <= 1'b0;
      strobe_r <= 1'b0;
      ostd_r   <= 1'b0;
      state_r  <= ST_SLEEP;
    end else begin
      word_r   <= word_nxt;
      phase_r  <= phase_nxt;
      strobe_r <= strobe_nxt;
      ostd_r   <= sy2_r[SY_OSTD];
      state_r  <= state_nxt;
    end
  end

  assign sample_bits     = word_r.sample_bits;
  assign overrange       = word_r.overrange;
  assign output_strobe   = strobe_r;
  assign output_standard = ostd_r;

  ////////////////////////////////////////////////////////////////////////
  // Registers: status, sticky events, mask
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] ist_nxt;
  logic [IRQ_W-1:0] imask_r;
  logic [IRQ_W-1:0] imask_nxt;
  logic [IRQ_W-1:0] ev;
  logic [31:0]      rdata_nxt;
  logic             irq_nxt;
  logic [31:0]      rdata_r;
  logic             irq_r;

  assign ev[IRQ_LOST]  = lost_ev && state_r == ST_RUN;
  assign ev[IRQ_OVR_A] = rise_ev && state_r == ST_RUN && !sleep_a
                         && enc_a.overrange;
  assign ev[IRQ_OVR_B] = b_ev && !rise_ev && state_r == ST_RUN && !sleep_b
                         && enc_b.overrange;

  // Write-one-clear with set winning, read data a cycle later
  always_comb begin
    ist_nxt   = ist_r;
    imask_nxt = imask_r;
    rdata_nxt = '0;
    if (reg_wr && reg_addr == REG_IRQ_STAT) begin
      ist_nxt = ist_r & ~reg_wdata[IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == REG_IRQ_MASK) begin
      imask_nxt = reg_wdata[IRQ_W-1:0];
    end
    ist_nxt = ist_nxt | ev;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS:   rdata_nxt = {25'h0, state_r, sy2_r[SY_OSTD],
                                   sleep_b, sleep_a, twos_on, stab_on};
        REG_IRQ_STAT: rdata_nxt = {29'h0, ist_r};
        REG_IRQ_MASK: rdata_nxt = {29'h0, imask_r};
        default:      rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r   <= '0;
      imask_r <= IRQ_MASK_RST;
      rdata_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      ist_r   <= ist_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = irq_r;

endmodule
`default_nettype wire

// ---- testbench/dcso_port_sva.sv ----
// Purpose: Pin level assertions for the sample output port
// Assumes: Bench sample clock period is 16 clk cycles
// Notes:   Bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module dcso_port_sva
  import dcso_pkg::*;
#(
  parameter int LOST_CYCLES = LOST_CYC
) (
  // Clock, reset and pins
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                sample_clock,
  input wire logic                sleep_input_a,
  input wire logic                sleep_input_b,
  input wire logic                output_standard_select,
  // Output bus
  input wire logic [SAMPLE_W-1:0] sample_bits,
  input wire logic                overrange,
  input wire logic                output_strobe,
  input wire logic                output_standard,
  // Register port
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire logic                irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Cycles since the sample clock pin last moved
  logic        sc_q;
  logic [15:0] idle_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_q     <= 1'b0;
      idle_cnt <= 16'h0;
    end else begin
      sc_q     <= sample_clock;
      idle_cnt <= (sc_q != sample_clock) ? 16'h0 : idle_cnt + 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Properties
  chk_sleep_quiet: assert property ((sleep_input_a && sleep_input_b)[*6]
    |=> !output_strobe && sample_bits == 10'h000) else $error("sleep busy");
  chk_word_rise: assert property ($rose(output_strobe)
    |-> $stable(sample_bits) && $stable(overrange)) else $error("A moved");
  chk_word_fall: assert property ($fell(output_strobe) &&
    !(sleep_input_a && sleep_input_b) |-> $stable(sample_bits))
    else $error("B word moved at strobe fall");
  chk_clip_value: assert property (overrange |-> sample_bits inside
    {10'h1FF, 10'h200, 10'h3FF, 10'h000}) else $error("word not clipped");
  chk_std_follow: assert property ($stable(output_standard_select)[*5]
    |-> output_standard == output_standard_select) else $error("std lag");
  chk_strobe_idle: assert property (int'(idle_cnt) > LOST_CYCLES + 8
    |-> !output_strobe) else $error("strobe with no sample clock");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_irq_masked: assert property (reg_wr && reg_addr == REG_IRQ_MASK &&
    reg_wdata[2:0] == 3'h0 |=> ##1 !irq) else $error("masked irq high");
  // Main scenarios
  cover property ($rose(output_strobe));
  cover property ($fell(output_strobe));
  cover property (overrange);
  cover property (irq);
endmodule
`default_nettype wire

// ---- testbench/dcso_capture.sv ----
// Purpose: Receiving capture logic on the far side of the output bus
// Assumes: Strobe edges are clean
// Notes:   Splits the bus into two channel words
`timescale 1ns/1ps
`default_nettype none
module dcso_capture
  import dcso_pkg::*;
(
  // Output bus
  input  wire logic [SAMPLE_W-1:0] sample_bits,
  input  wire logic                overrange,
  input  wire logic                output_strobe,
  // Captured words
  output var  dcso_word_s          word_a,
  output var  dcso_word_s          word_b
);
  // Channel A on rising strobe, B on falling strobe
  always_ff @(posedge output_strobe) begin
    word_a <= {overrange, sample_bits};
  end
  always_ff @(negedge output_strobe) begin
    word_b <= {overrange, sample_bits};
  end
endmodule
`default_nettype wire

// ---- testbench/dcso_port_tb_top.sv ----
// Purpose: Self-checking bench for the sample output port
// Assumes: Sample clock 64 ns, clock lost limit shortened
// Notes:   Table rows first, then sleep, interrupt and lost clock
`timescale 1ns/1ps
`default_nettype none
module dcso_port_tb_top
  import dcso_pkg::*;
;
  localparam int LOST = 40;
  typedef struct packed {
    logic [1:0]  fss;
    logic [11:0] code;
    logic [9:0]  word;
    logic        ovr;
  } dcso_row_s;
  dcso_row_s rows [8] = '{
    '{2'h0, 12'h000, 10'h200, 1'b0}, '{2'h1, 12'h000, 10'h000, 1'b0},
    '{2'h1, 12'h1FF, 10'h1FF, 1'b0}, '{2'h1, 12'h200, 10'h1FF, 1'b1},
    '{2'h0, 12'hDFF, 10'h000, 1'b1}, '{2'h3, 12'hF00, 10'h300, 1'b0},
    '{2'h2, 12'h100, 10'h300, 1'b0}, '{2'h0, 12'hE00, 10'h000, 1'b0}};
  logic clk, rst, sample_clock, sleep_input_a, sleep_input_b;
  logic output_standard_select, overrange, output_strobe, output_standard;
  logic reg_wr, reg_rd, irq;
  logic [1:0] format_stabilizer_select;
  logic signed [CORE_W-1:0] core_code_a, core_code_b;
  logic [SAMPLE_W-1:0] sample_bits;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  dcso_word_s cap_a, cap_b;
  int errors, num_checks;
  int sc_hi = 32;
  bit sc_run = 1'b1;
  dcso_port #(.LOST_CYCLES(LOST)) dut (
    .clk(clk), .rst(rst), .sample_clock(sample_clock),
    .sleep_input_a(sleep_input_a), .sleep_input_b(sleep_input_b),
    .output_standard_select(output_standard_select),
    .format_stabilizer_select(format_stabilizer_select),
    .core_code_a(core_code_a), .core_code_b(core_code_b),
    .sample_bits(sample_bits), .overrange(overrange),
    .output_strobe(output_strobe), .output_standard(output_standard),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  dcso_capture u_cap (.sample_bits(sample_bits), .overrange(overrange),
    .output_strobe(output_strobe), .word_a(cap_a), .word_b(cap_b));
  ////////////////////////////////////////////////////////////////////////
  // Clocks, sample clock stands low while stopped
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    sample_clock = 1'b0;
    #1;
    forever begin
      if (sc_run) begin
        sample_clock = 1'b1;
        #(sc_hi);
      end
      sample_clock = 1'b0;
      #(64 - sc_hi);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input string nm, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic close_out;
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #40000;
    errors++;
    close_out;
  end
  // Main sequence
  initial begin
    {rst, sleep_input_a, sleep_input_b, output_standard_select} = 4'h8;
    {reg_wr, reg_rd, format_stabilizer_select} = 4'h0;
    {core_code_a, core_code_b, reg_addr, reg_wdata} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      format_stabilizer_select <= rows[i].fss;
      core_code_a <= rows[i].code;
      output_standard_select <= i[0];
      sc_hi = rows[i].fss[1] ? 20 : 32;
      repeat (100) @(posedge clk);
      check("word_a", {21'h0, rows[i].ovr, rows[i].word},
            32'(cap_a));
      check("word_b", rows[i].fss[0] ? 32'h0 : 32'h200,
            32'(cap_b));
      rd(REG_STATUS);
      check("status", {27'h1, i[0], 2'h0, rows[i].fss[0],
            rows[i].fss[1]}, d);
      check("std_out", 32'(i[0]), 32'(output_standard));
    end
    sleep_input_a <= 1'b1;
    repeat (60) @(posedge clk);
    check("sleep_a", 32'h0, 32'(cap_a));
    check("awake_b", 32'h200, 32'(cap_b));
    sleep_input_b <= 1'b1;
    repeat (30) @(posedge clk);
    check("sleep_bus", 32'h0, {sample_bits, output_strobe});
    {sleep_input_a, sleep_input_b} <= 2'h0;
    core_code_a <= 12'h7FF;
    core_code_b <= 12'h800;
    repeat (60) @(posedge clk);
    rd(REG_IRQ_STAT);
    check("ovr_event", 32'h6, d & 32'h6);
    check("irq_masked", 32'h0, 32'(irq));
    wr(REG_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    check("irq_on", 32'h1, 32'(irq));
    wr(REG_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check("irq_mask_off", 32'h0, 32'(irq));
    wr(REG_IRQ_MASK, 32'h2);
    {core_code_a, core_code_b} <= '0;
    repeat (40) @(posedge clk);
    wr(REG_IRQ_STAT, 32'h7);
    repeat (3) @(posedge clk);
    check("irq_off", 32'h0, 32'(irq));
    rd(4'hC);
    check("unmapped", 32'h0, d);
    sc_run = 1'b0;
    repeat (LOST + 40) @(posedge clk);
    rd(REG_STATUS);
    check("lost", 32'h40, d & 32'h60);
    rd(REG_IRQ_STAT);
    check("lost_event", 32'h1, d & 32'h1);
    sc_run = 1'b1;
    repeat (80) @(posedge clk);
    rd(REG_STATUS);
    check("resume", 32'h20, d & 32'h60);
    // Mid-run reset: outputs clear, mask back to its reset value
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset_bus", 32'h0, {overrange, sample_bits, output_strobe});
    check("reset_misc", 32'h0, {|reg_rdata, irq, output_standard});
    rst <= 1'b0;
    rd(REG_IRQ_MASK);
    check("mask_reset", 32'h0, d);
    close_out;
  end
endmodule
bind dcso_port dcso_port_sva #(.LOST_CYCLES(LOST_CYCLES)) u_sva (
  .clk(clk), .rst(rst), .sample_clock(sample_clock),
  .sleep_input_a(sleep_input_a), .sleep_input_b(sleep_input_b),
  .output_standard_select(output_standard_select),
  .sample_bits(sample_bits), .overrange(overrange),
  .output_strobe(output_strobe), .output_standard(output_standard),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire
